// ===== include/pmlh_pkg.sv
// shared constants and types for the master local-side handshake block
package pmlh_pkg;
  localparam int         LAD_W         = 32;   // local address/data width
  localparam int         CMD_W         = 4;    // command width
  localparam int         TSR_W         = 10;   // progress bus width
  localparam int         CMD_WRITE_BIT = 0;    // command bit 0 set: write
  localparam logic       STROBE_IDLE   = 1'b1; // idle level of low strobes
  localparam logic [9:0] TSR_RESET     = 10'h000;
  // progress bus bit positions
  localparam int TSR_REQUEST = 0;
  localparam int TSR_GRANT   = 1;
  localparam int TSR_ADR     = 2;
  localparam int TSR_DAT     = 3;
  localparam int TSR_LAT     = 4;
  localparam int TSR_RETRY   = 5;
  localparam int TSR_DISC_ND = 6;
  localparam int TSR_DISC_D  = 7;
  localparam int TSR_XFR     = 8;
  localparam int TSR_WIDE    = 9;
  // transaction sequencer states
  typedef enum logic [2:0] {
    PMLH_IDLE,
    PMLH_REQ,
    PMLH_ADDR,
    PMLH_APH,
    PMLH_DATA,
    PMLH_TURN
  } pmlh_state_t;
endpackage

// ===== design/pmlh_buf.sv
// two-entry data buffer between local side and bus side
`timescale 1ns/1ps
`default_nettype none
module pmlh_buf #(
  parameter int W = 32
) (
  input  wire logic         clock_in,
  input  wire logic         rst_in,
  input  wire logic         ce_in,
  input  wire logic         flush_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  output logic              out_valid_out,
  output logic [W-1:0]      out_data_out,
  input  wire logic         out_ready_in
);
  logic         v1;        // second entry occupied
  logic [W-1:0] d1;        // second entry data
  logic         next_v0;
  logic         next_v1;
  logic         next_room;
  logic [W-1:0] next_d0;
  logic [W-1:0] next_d1;

  // head always sits in entry 0, so the head output is a plain flop
  always_comb
  begin
    next_v0 = out_valid_out;
    next_v1 = v1;
    next_d0 = out_data_out;
    next_d1 = d1;
    if (out_ready_in && out_valid_out)
    begin
      // pop: shift second entry forward
      next_v0 = v1;
      next_d0 = d1;
      next_v1 = 1'b0;
    end
    if (in_valid_in && in_ready_out)
    begin
      if (!next_v0)
      begin
        next_v0 = 1'b1;
        next_d0 = in_data_in;
      end
      else
      begin
        next_v1 = 1'b1;
        next_d1 = in_data_in;
      end
    end
    if (flush_in)
    begin
      // flush wins over a push in the same cycle
      next_v0 = 1'b0;
      next_v1 = 1'b0;
    end
    next_room = !next_v1;
  end

  // registers only
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      out_valid_out <= 1'b0;
      v1            <= 1'b0;
      in_ready_out  <= 1'b1;
      out_data_out  <= '0;
      d1            <= '0;
    end
    else if (ce_in)
    begin
      out_valid_out <= next_v0;
      v1            <= next_v1;
      in_ready_out  <= next_room;
      out_data_out  <= next_d0;
      d1            <= next_d1;
    end
  end
endmodule // pmlh_buf
`default_nettype wire

// ===== design/pmlh_core.sv
// master local-side handshake: request, address accept, data pacing, status
//
// Overview of operation
// - write stalls while local ready is high
// - read inserts bus waits when local not ready
// - read burst bus waits only from local ready
// - ready sampled one cycle before data moves
// - address accept low takes requested transaction
// - core ack low: read data valid/write taken
// - read stalls while core ack is high
// - target bus waits drive core ack high
// - beat-done pulses for each local data word
// - ten-bit progress bus reports transaction state
// - progress bit 8 marks previous bus beat
`timescale 1ns/1ps
`default_nettype none
module pmlh_core (
  input  wire logic                      clock_in,
  input  wire logic                      rst_in,
  input  wire logic                      ce_in,
  // local side
  input  wire logic                      request_narrow_low_in,
  input  wire logic                      request_wide_low_in,
  input  wire logic                      end_transfer_low_in,
  input  wire logic                      local_ready_low_in,
  input  wire logic [pmlh_pkg::LAD_W-1:0] local_addr_data_in,
  input  wire logic [pmlh_pkg::CMD_W-1:0] local_cmd_in,
  output logic                           address_accept_low_out,
  output logic                           core_data_ack_low_out,
  output logic                           local_beat_done_low_out,
  output logic [pmlh_pkg::LAD_W-1:0]      local_data_out,
  output logic [pmlh_pkg::TSR_W-1:0]      master_progress_bus_out,
  // bus side
  input  wire logic                      bus_grant_in,
  input  wire logic                      bus_beat_in,
  input  wire logic                      bus_stop_in,
  input  wire logic                      bus_lat_expired_in,
  input  wire logic                      bus_ack64_in,
  input  wire logic [pmlh_pkg::LAD_W-1:0] bus_rdata_in,
  output logic                           bus_req_out,
  output logic                           bus_addr_phase_out,
  output logic [pmlh_pkg::LAD_W-1:0]      bus_addr_out,
  output logic [pmlh_pkg::CMD_W-1:0]      bus_cmd_out,
  output logic                           bus_wide_out,
  output logic                           bus_last_out,
  output logic                           bus_wdata_valid_out,
  output logic [pmlh_pkg::LAD_W-1:0]      bus_wdata_out,
  output logic                           bus_rdata_ready_out
);
  import pmlh_pkg::*;

  // low-active strobe to positive meaning
  function automatic logic active(input logic low_sig);
    return ~low_sig;
  endfunction

  pmlh_state_t       state;        // sequencer state
  pmlh_state_t       next_state;
  logic              wr;           // current transaction is a write
  logic              next_wr;
  logic              last_pend;    // end of transaction requested
  logic              next_last_pend;
  logic              beats_seen;   // at least one bus beat so far
  logic              next_beats_seen;
  logic              next_addr_ack;
  logic              next_data_ack;
  logic              next_req;
  logic              next_aphase;
  logic              next_blast;
  logic              next_wide;
  logic [LAD_W-1:0]  next_rdata;
  logic [LAD_W-1:0]  next_addr;
  logic [CMD_W-1:0]  next_cmd;
  logic [TSR_W-1:0]  next_tsr;
  // buffer wiring
  logic              buf_room;     // buffer can take a word
  logic              buf_valid;    // buffer head valid
  logic [LAD_W-1:0]  buf_head;
  logic              buf_push;
  logic [LAD_W-1:0]  buf_din;
  logic              buf_pop;
  logic              buf_flush;
  // per-cycle events
  logic              xfer;         // local word moves this cycle
  logic              wbeat;        // bus takes a write word
  logic              rbeat;        // bus delivers a read word
  logic              beat;
  logic              rd_take;      // read word handed to local next cycle
  logic              fin;          // data phase ends this cycle

  // one buffer serves both directions; direction picks who fills it
  pmlh_buf #(
    .W (LAD_W)
  ) u_buf (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .ce_in         (ce_in),
    .flush_in      (buf_flush),
    .in_valid_in   (buf_push),
    .in_data_in    (buf_din),
    .in_ready_out  (buf_room),
    .out_valid_out (buf_valid),
    .out_data_out  (buf_head),
    .out_ready_in  (buf_pop)
  );

  // the buffer's own flops face the bus directly
  assign bus_wdata_valid_out = buf_valid & wr & (state == PMLH_DATA);
  assign bus_wdata_out       = buf_head;
  assign bus_rdata_ready_out = buf_room;

  // next-value logic for the whole sequencer
  always_comb
  begin
    next_state      = state;
    next_wr         = wr;
    next_last_pend  = last_pend;
    next_beats_seen = beats_seen;
    next_wide       = bus_wide_out;
    next_addr       = bus_addr_out;
    next_cmd        = bus_cmd_out;
    next_rdata      = local_data_out;
    next_blast      = bus_last_out;
    next_tsr        = master_progress_bus_out;
    buf_flush       = 1'b0;
    // a word moves on the local side in every acked cycle
    xfer  = !core_data_ack_low_out;
    wbeat = bus_beat_in && (state == PMLH_DATA) && wr && buf_valid;
    // read beats stall only when the buffer is full of unread words
    rbeat = bus_beat_in && (state == PMLH_DATA) && !wr && buf_room;
    beat  = wbeat || rbeat;
    buf_push = (xfer && wr) || rbeat;
    buf_din  = wr ? local_addr_data_in : bus_rdata_in;
    // read ack needs local ready now and a word in hand
    rd_take = !wr && buf_valid && active(local_ready_low_in)
              && (state == PMLH_DATA || state == PMLH_TURN);
    buf_pop = wr ? wbeat : rd_take;
    if (rd_take)
    begin
      next_rdata = buf_head;
    end
    // write ack only when a slot is free counting the word now moving
    next_data_ack = STROBE_IDLE;
    if (rd_take)
    begin
      next_data_ack = 1'b0;
    end
    // no write ack in a stop cycle: a word taken then would be stranded
    // in the buffer during turnaround and the sequencer would never idle
    else if (wr && state == PMLH_DATA && active(local_ready_low_in)
             && !last_pend && !bus_stop_in && buf_room
             && !(buf_valid && xfer))
    begin
      next_data_ack = 1'b0;
    end
    fin = 1'b0;
    if (beat)
    begin
      next_beats_seen = 1'b1;
    end
    case (state)
      PMLH_IDLE:
      begin
        // a one-cycle request is enough to start
        if (active(request_narrow_low_in) || active(request_wide_low_in))
        begin
          next_state      = PMLH_REQ;
          next_wide       = active(request_wide_low_in);
          next_last_pend  = 1'b0;
          next_beats_seen = 1'b0;
          next_blast      = 1'b0;
          next_tsr        = TSR_RESET;
        end
      end
      PMLH_REQ:
      begin
        if (bus_grant_in)
        begin
          next_state = PMLH_ADDR;
        end
      end
      PMLH_ADDR:
      begin
        // local presents address and command while accept is low
        next_addr  = local_addr_data_in;
        next_cmd   = local_cmd_in;
        next_wr    = local_cmd_in[CMD_WRITE_BIT];
        next_state = PMLH_APH;
      end
      PMLH_APH:
      begin
        next_state = PMLH_DATA;
      end
      PMLH_DATA:
      begin
        if (bus_lat_expired_in)
        begin
          next_tsr[TSR_LAT] = 1'b1;
          next_last_pend    = 1'b1;
        end
        if (bus_ack64_in && bus_wide_out)
        begin
          next_tsr[TSR_WIDE] = 1'b1;
        end
        if (bus_stop_in)
        begin
          // target ends it; classify by beat history
          fin = 1'b1;
          next_tsr[TSR_DISC_D]  = beat;
          next_tsr[TSR_RETRY]   = !beat && !beats_seen;
          next_tsr[TSR_DISC_ND] = !beat && beats_seen;
          buf_flush = wr;
        end
        else if (bus_last_out && beat)
        begin
          fin = 1'b1;
        end
        else if (wr && last_pend && !buf_valid && !xfer && !bus_last_out)
        begin
          fin = 1'b1;
        end
        if (fin)
        begin
          next_state = PMLH_TURN;
          next_blast = 1'b0;
        end
        else if (wr ? (last_pend && buf_valid && buf_room && !xfer
                       && !wbeat)
                    : (last_pend || bus_lat_expired_in))
        begin
          next_blast = 1'b1;
        end
      end
      PMLH_TURN:
      begin
        // reads drain leftover words to the local side first
        if (!buf_valid && core_data_ack_low_out)
        begin
          next_state = PMLH_IDLE;
        end
      end
      default:
      begin
        next_state = PMLH_IDLE;
      end
    endcase
    // end request is taken any time during the transaction
    if (state != PMLH_IDLE && active(end_transfer_low_in))
    begin
      next_last_pend = 1'b1;
    end
    next_addr_ack = (next_state == PMLH_ADDR) ? 1'b0 : STROBE_IDLE;
    next_req      = (next_state == PMLH_REQ);
    next_aphase   = (next_state == PMLH_APH);
    // progress bus follows the sequencer
    next_tsr[TSR_REQUEST] = next_req;
    next_tsr[TSR_GRANT]   = (next_state == PMLH_ADDR)
                            || (next_state == PMLH_APH)
                            || (next_state == PMLH_DATA);
    next_tsr[TSR_ADR]     = next_aphase;
    next_tsr[TSR_DAT]     = (next_state == PMLH_DATA);
    next_tsr[TSR_XFR]     = beat;
  end

  // registers only; strobes come up idle
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state                   <= PMLH_IDLE;
      wr                      <= 1'b0;
      last_pend               <= 1'b0;
      beats_seen              <= 1'b0;
      address_accept_low_out  <= STROBE_IDLE;
      core_data_ack_low_out   <= STROBE_IDLE;
      local_beat_done_low_out <= STROBE_IDLE;
      local_data_out          <= '0;
      master_progress_bus_out <= TSR_RESET;
      bus_req_out             <= 1'b0;
      bus_addr_phase_out      <= 1'b0;
      bus_addr_out            <= '0;
      bus_cmd_out             <= '0;
      bus_wide_out            <= 1'b0;
      bus_last_out            <= 1'b0;
    end
    else if (ce_in)
    begin
      state                   <= next_state;
      wr                      <= next_wr;
      last_pend               <= next_last_pend;
      beats_seen              <= next_beats_seen;
      address_accept_low_out  <= next_addr_ack;
      core_data_ack_low_out   <= next_data_ack;
      // done pulses exactly with the acked word
      local_beat_done_low_out <= next_data_ack;
      local_data_out          <= next_rdata;
      master_progress_bus_out <= next_tsr;
      bus_req_out             <= next_req;
      bus_addr_phase_out      <= next_aphase;
      bus_addr_out            <= next_addr;
      bus_cmd_out             <= next_cmd;
      bus_wide_out            <= next_wide;
      bus_last_out            <= next_blast;
    end
  end

  // ready as seen at the last enabled edge, for checking only
  logic rdy_seen;
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      rdy_seen <= 1'b0;
    end
    else if (ce_in)
    begin
      rdy_seen <= active(local_ready_low_in);
    end
  end

  ack_done_a: assert property (@(posedge clock_in) disable iff (rst_in)
    core_data_ack_low_out == local_beat_done_low_out)
    else $error("beat done differs from data ack");
  ack_ready_a: assert property (@(posedge clock_in) disable iff (rst_in)
    !core_data_ack_low_out |-> rdy_seen)
    else $error("data ack without prior local ready");
  accept_pulse_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (ce_in && !address_accept_low_out) |=> address_accept_low_out)
    else $error("address accept longer than one cycle");
  accept_state_a: assert property (@(posedge clock_in) disable iff (rst_in)
    !address_accept_low_out |-> master_progress_bus_out[TSR_GRANT]
      && !master_progress_bus_out[TSR_ADR])
    else $error("address accept outside grant");
  cmd_capture_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (ce_in && !address_accept_low_out) |=>
      bus_cmd_out == $past(local_cmd_in) && bus_addr_phase_out)
    else $error("command not captured at address accept");
  xfr_bit_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (ce_in && bus_beat_in && state == PMLH_DATA
      && (wr ? bus_wdata_valid_out : bus_rdata_ready_out))
      |=> master_progress_bus_out[TSR_XFR])
    else $error("progress bit 8 missed a bus beat");
  read_wait_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (state == PMLH_DATA && !wr && !bus_rdata_ready_out)
      |-> buf_valid && !rdy_seen)
    else $error("bus wait without local hold-off");
  dat_phase_a: assert property (@(posedge clock_in) disable iff (rst_in)
    master_progress_bus_out[TSR_DAT] == (state == PMLH_DATA))
    else $error("data phase bit disagrees with state");
  idle_quiet_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (state == PMLH_IDLE) |-> core_data_ack_low_out && address_accept_low_out)
    else $error("strobe active while idle");
endmodule // pmlh_core
`default_nettype wire

// ===== bench/pmlh_local_model.sv
// local-side user logic that requests and paces master transfers
`timescale 1ns/1ps
`default_nettype none
module pmlh_local_model (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        run_in,
  input  wire logic        wide_in,
  input  wire logic        write_in,
  input  wire logic        stall_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [3:0]  count_in,
  input  wire logic        accept_low_in,
  input  wire logic        ack_low_in,
  output logic             request_narrow_low_out,
  output logic             request_wide_low_out,
  output logic             end_transfer_low_out,
  output logic             local_ready_low_out,
  output logic [31:0]      local_addr_data_out,
  output logic [3:0]       local_cmd_out
);
  logic       was_run; // run level one edge ago
  logic       in_data; // address taken, words moving
  logic [3:0] k;       // words acknowledged so far
  // all strobes idle outside a transfer; released lines toggle
  always @(posedge clock_in)
  begin
    if (rst_in || !run_in)
    begin
      request_narrow_low_out <= 1'h1;
      request_wide_low_out <= 1'h1;
      end_transfer_low_out <= 1'h1;
      local_ready_low_out <= 1'h1;
      local_addr_data_out <= rst_in ? 32'h0 : ~local_addr_data_out;
      local_cmd_out <= rst_in ? 4'h0 : ~local_cmd_out;
      in_data <= 1'h0;
      k <= 4'h0;
    end
    else
    begin
      // one-cycle request on the rise of run
      request_narrow_low_out <= was_run | wide_in;
      request_wide_low_out <= was_run | ~wide_in;
      end_transfer_low_out <= 1'h1;
      if (!was_run)
      begin
        // held until accept is seen, tolerating a late accept
        local_addr_data_out <= addr_in;
        local_cmd_out <= {3'h3, write_in};
      end
      else if (!accept_low_in && !in_data)
      begin
        in_data <= 1'h1;
        local_addr_data_out <= ~addr_in;
      end
      if (in_data || !accept_low_in)
        local_ready_low_out <= stall_in;
      if (in_data && !ack_low_in)
      begin
        // word k is held until its ack cycle ends
        k <= k + 4'h1;
        if (write_in)
          local_addr_data_out <= ~addr_in + {28'h0, k} + 32'h1;
        if (k + 4'h1 == count_in)
          end_transfer_low_out <= 1'h0;
      end
    end
    was_run <= run_in & ~rst_in;
  end
endmodule // pmlh_local_model
`default_nettype wire

// ===== bench/tb.sv
// self-checking bench for the master local-side handshake block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pmlh_pkg::*;
  logic clock_in = 1'h0;
  logic rst_in = 1'h1;
  logic run = 1'h0, wide = 1'h0, wr = 1'h0, stall = 1'h0;
  logic grant = 1'h0, beat = 1'h0, stop = 1'h0, lat = 1'h0;
  logic ack64 = 1'h0, fired = 1'h0, cls = 1'h0, q;
  logic ce = 1'h1;
  logic prev_q = 1'h0, prev_gr = 1'h0, prev_rq = 1'h0;
  logic prev_rdy = 1'h1, prev_acc = 1'h1;
  logic [3:0] nw = 4'h1;
  logic [31:0] addr = 32'h0, r;
  logic [9:0] exp_fl = 10'h0; // sticky status expected
  logic req_n, wreq_n, end_n, rdy_n, acc_n, ack_n, done_n;
  logic breq, baph, bwide, blast, wvalid, rready;
  logic [3:0] cmd, bcmd;
  logic [9:0] prog;
  logic [31:0] lad, ldat, baddr, wdata;
  int seed = 32'h5d55;
  int n_errors = 0, n_checks = 0, mode = 0, trig = 0;
  int nb = 0, rb = 0, ri = 0, wi = 0, k;
  wire [31:0] bus_rdata = ~addr + rb; // read word rb
  always #2 clock_in = ~clock_in;
  pmlh_local_model u_pmlh_local_model (.clock_in(clock_in),
    .rst_in(rst_in), .run_in(run), .wide_in(wide), .write_in(wr),
    .stall_in(stall), .addr_in(addr), .count_in(nw),
    .accept_low_in(acc_n), .ack_low_in(ack_n),
    .request_narrow_low_out(req_n), .request_wide_low_out(wreq_n),
    .end_transfer_low_out(end_n), .local_ready_low_out(rdy_n),
    .local_addr_data_out(lad), .local_cmd_out(cmd));
  pmlh_core u_pmlh_core (.clock_in(clock_in), .rst_in(rst_in),
    .ce_in(ce), .request_narrow_low_in(req_n),
    .request_wide_low_in(wreq_n), .end_transfer_low_in(end_n),
    .local_ready_low_in(rdy_n), .local_addr_data_in(lad),
    .local_cmd_in(cmd), .address_accept_low_out(acc_n),
    .core_data_ack_low_out(ack_n), .local_beat_done_low_out(done_n),
    .local_data_out(ldat), .master_progress_bus_out(prog),
    .bus_grant_in(grant), .bus_beat_in(beat), .bus_stop_in(stop),
    .bus_lat_expired_in(lat), .bus_ack64_in(ack64),
    .bus_rdata_in(bus_rdata), .bus_req_out(breq),
    .bus_addr_phase_out(baph), .bus_addr_out(baddr),
    .bus_cmd_out(bcmd), .bus_wide_out(bwide), .bus_last_out(blast),
    .bus_wdata_valid_out(wvalid), .bus_wdata_out(wdata),
    .bus_rdata_ready_out(rready));
  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // bus-side target: random grant and waits, one stop or expiry
  always @(posedge clock_in)
  begin
    r = $random(seed);
    grant <= breq & r[0];
    beat <= r[1] | r[2]; // target waits now and then
    stall <= r[4:3] == 2'h0;
    stop <= 1'h0;
    lat <= 1'h0;
    if (run && prog[TSR_DAT] && !fired && nb >= trig && mode != 0)
    begin
      fired <= 1'h1;
      stop <= mode == 1;
      lat <= mode == 2;
    end
    if (!run)
      fired <= 1'h0;
  end
  // port monitor; reads pre-edge values so it never races the design
  always @(posedge clock_in)
  begin
    q = beat & prog[TSR_DAT] & (wr ? wvalid : rready);
    if (!run || !ce)
    begin
      nb <= 0;
      rb <= 0;
      ri <= 0;
      wi <= 0;
      cls <= 1'h0;
      exp_fl <= 10'h0;
    end
    else
    begin
      chk1(done_n, ack_n);
      chk1(acc_n, ~prev_gr);
      chk1(prog[TSR_XFR], prev_q);
      chk1(prog[TSR_REQUEST], breq);
      if (prev_rq)
        chk1(breq, 1'h1);
      if (!ack_n)
        chk1(prev_rdy, 1'h0);
      if (!prev_acc)
      begin
        chk32(baddr, addr);
        chk32({28'h0, bcmd}, {28'h0, 3'h3, wr});
        chk1(baph & prog[TSR_ADR], 1'h1);
      end
      if (prog[TSR_DAT])
        chk1(bwide, wide);
      if (q)
        nb <= nb + 1;
      if (q && wr)
      begin
        chk32(wdata, ~addr + wi);
        wi <= wi + 1;
      end
      if (q && !wr)
        rb <= rb + 1;
      if (!ack_n && !wr)
      begin
        chk32(ldat, ~addr + ri);
        chk1(ri < rb, 1'h1);
        ri <= ri + 1;
      end
      // termination kind worked out from what the target did
      if (stop && prog[TSR_DAT] && !cls)
      begin
        cls <= 1'h1;
        exp_fl[7] <= q;
        exp_fl[5] <= !q && nb == 0;
        exp_fl[6] <= !q && nb != 0;
      end
      if (lat && prog[TSR_DAT])
        exp_fl[4] <= 1'h1;
      if (prog[TSR_DAT] && wide && ack64)
        exp_fl[9] <= 1'h1;
    end
    prev_q <= q & run;
    prev_gr <= breq & grant;
    prev_rq <= ~(req_n & wreq_n);
    prev_rdy <= rdy_n;
    prev_acc <= acc_n;
  end
  // one transfer: m 0 local end, 1 target stop, 2 expiry; t beats first
  task automatic xfer(input logic w, input logic wd, input int m,
                      input int t);
    int i;
    logic seen;
    wr <= w;
    wide <= wd;
    mode <= m;
    trig <= t;
    addr <= $random(seed);
    nw <= 4'h1 + 4'($random(seed) & 7);
    ack64 <= 1'($random(seed));
    @(posedge clock_in);
    run <= 1'h1;
    seen = 1'h0;
    i = 0;
    // leave once the data phase and grant are over, ack is idle and read words are drained
    while (!(seen && !prog[TSR_DAT] && !prog[TSR_GRANT] && ack_n
             && ri == rb) && i < 2000)
    begin
      @(posedge clock_in);
      seen = seen | prog[TSR_DAT];
      i++;
    end
    if (i >= 2000)
    begin
      n_errors++;
      tally_and_finish();
    end
    repeat (3) @(posedge clock_in);
    chk32({26'h0, prog[9:4]}, {26'h0, exp_fl[9:4]});
    chk32({28'h0, prog[3:0]}, 32'h0);
    chk1(ack_n & acc_n & done_n, 1'h1);
    run <= 1'h0;
    repeat (2) @(posedge clock_in);
    $display("transfer w%0d m%0d t%0d done", w, m, t);
  endtask
  initial
  begin
    repeat (10) @(posedge clock_in);
    chk1(acc_n & ack_n & done_n, 1'h1);
    chk32({22'h0, prog}, 32'h0);
    rst_in <= 1'h0;
    @(posedge clock_in);
    // enable low: a request pulse must leave the block frozen
    ce <= 1'h0;
    run <= 1'h1;
    repeat (4) @(posedge clock_in);
    chk1(breq, 1'h0);
    chk32({22'h0, prog}, 32'h0);
    run <= 1'h0;
    ce <= 1'h1;
    repeat (2) @(posedge clock_in);
    $display("enable freeze test done");
    // corner cases: retry at once, stops after beats, expiry, wide
    xfer(1'h1, 1'h0, 0, 0);
    xfer(1'h0, 1'h0, 0, 0);
    xfer(1'h1, 1'h1, 1, 0);
    xfer(1'h0, 1'h0, 1, 2);
    xfer(1'h1, 1'h0, 1, 2);
    xfer(1'h0, 1'h1, 2, 1);
    for (k = 0; k < 16; k++)
      xfer(1'($random(seed)), 1'($random(seed)), k % 3, k % 4);
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
